// ### core/indexer_core.sv
// Indexer command interpreter: AHB-Lite registers, buffered command queue with
// nested loops and delays, immediate kill/pause/output, jog and limit motion.
// Assumes pins arrive asynchronously and the host writes argument before opcode.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module indexer_core #(
   parameter int unsigned TICK_CYCLES = indexer_pkg::TICK_CYCLES,
   parameter int unsigned QUEUE_DEPTH = 32,
   parameter int unsigned LOOP_DEPTH = indexer_pkg::LOOP_DEPTH_MAX,
   parameter int unsigned GPO_W = 8
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire indexer_pkg::pins_type pins_raw,
   output logic [GPO_W-1:0] gpo,
   output logic [31:0] motor_speed,
   output logic motor_dir,
   output logic motor_run,
   output logic [4:0] trigger
);
   localparam int unsigned QW = $clog2(QUEUE_DEPTH);
   localparam int unsigned DW = $clog2(LOOP_DEPTH);

   function automatic logic arg_ok(input logic [7:0] op, input logic [31:0] arg);
      unique case (op)
         indexer_pkg::OP_JOG_ACCEL:
            return arg >= indexer_pkg::JOG_ACCEL_MIN && arg <= indexer_pkg::JOG_ACCEL_MAX;
         indexer_pkg::OP_JOG_SPEED: return arg <= indexer_pkg::JOG_SPEED_MAX;
         indexer_pkg::OP_LIMIT_DECEL:
            return arg >= indexer_pkg::LIMIT_DECEL_MIN && arg <= indexer_pkg::LIMIT_DECEL_MAX;
         indexer_pkg::OP_END_STOP: return arg <= indexer_pkg::END_STOP_MAX;
         indexer_pkg::OP_LOOP_BEGIN: return arg <= indexer_pkg::LOOP_COUNT_MAX;
         default: return 1'b1;
      endcase
   endfunction : arg_ok

   function automatic logic [31:0] step_down(input logic [31:0] cur, input logic [31:0] step);
      return (cur > step) ? cur - step : 32'h0000_0000;
   endfunction : step_down

   // Bus slave
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_word;
   logic [31:0] arg_q;
   logic addr_rd;
   assign addr_rd = hsel && hready && htrans[1] && !hwrite;
   assign hrdata = hrdata_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_q <= hsel && hready && htrans[1] && hwrite;
         wr_addr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
         if (addr_rd) begin
            hrdata_q <= (haddr[31:8] == 24'h00_0000) ? rd_word : 32'h0000_0000;
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         arg_q <= 32'h0000_0000;
      end else if (wr_pend_q && wr_addr_q == indexer_pkg::OFF_CMD_ARG) begin
         arg_q <= hwdata;
      end
   end

   // Command decode
   logic issue;
   logic [7:0] op_in;
   logic kill;
   logic out_set;
   logic pause_cmd;
   logic cont_cmd;
   logic buffered;
   assign issue = wr_pend_q && wr_addr_q == indexer_pkg::OFF_CMD_OP;
   assign op_in = hwdata[7:0];
   assign kill = issue && (op_in == indexer_pkg::OP_KILL ||
                           op_in == indexer_pkg::OP_KILL_LONG);
   assign out_set = issue && op_in == indexer_pkg::OP_OUTPUT_SET;
   assign pause_cmd = issue && op_in == indexer_pkg::OP_PAUSE;
   assign cont_cmd = issue && op_in == indexer_pkg::OP_CONTINUE;
   assign buffered = issue && op_in >= indexer_pkg::OP_LOOP_BEGIN &&
                     op_in <= indexer_pkg::OP_DELAY;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         gpo <= '0;
      end else if (out_set) begin
         gpo <= arg_q[GPO_W-1:0];
      end
   end

   // Pin synchroniser: a change counts once stages two and three agree
   logic [9:0] pin_s1_q;
   logic [9:0] pin_s2_q;
   logic [9:0] pin_s3_q;
   logic [9:0] pins_q;
   indexer_pkg::pins_type pins;
   assign pins = indexer_pkg::pins_type'(pins_q);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_s1_q <= 10'h000;
         pin_s2_q <= 10'h000;
         pin_s3_q <= 10'h000;
         pins_q <= 10'h000;
      end else begin
         pin_s1_q <= pins_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pins_q <= (pin_s2_q & pin_s3_q) | (pins_q & (pin_s2_q ^ pin_s3_q));
      end
   end

   // Millisecond tick
   logic [31:0] tick_cnt_q;
   logic tick_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
         tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt_q + 1;
      end
   end

   // Command queue and executor
   indexer_pkg::cmd_entry_type queue_mem [QUEUE_DEPTH];
   indexer_pkg::cmd_entry_type cur;
   indexer_pkg::exec_state_type state_q;
   logic [QW:0] wr_ptr_q;
   logic [QW:0] rd_ptr_q;
   logic [15:0] cnt_q [LOOP_DEPTH];
   logic [QW:0] ret_q [LOOP_DEPTH];
   logic [LOOP_DEPTH-1:0] stop_q;
   logic [DW:0] depth_q;
   logic [DW-1:0] top;
   logic [31:0] delay_q;
   logic pause_q;
   logic reclaim;
   logic full;
   logic push;
   logic exec_go;
   assign cur = queue_mem[rd_ptr_q[QW-1:0]];
   assign top = DW'(depth_q - 1'b1);
   assign reclaim = rd_ptr_q == wr_ptr_q && depth_q == '0 && state_q == indexer_pkg::EX_RUN;
   assign full = !reclaim && wr_ptr_q == (QW+1)'(QUEUE_DEPTH);
   assign push = buffered && !full;
   assign exec_go = state_q == indexer_pkg::EX_RUN && !pause_q && rd_ptr_q != wr_ptr_q && !kill;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         queue_mem[reclaim ? QW'(0) : wr_ptr_q[QW-1:0]] <= '{op: op_in, arg: arg_q};
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         depth_q <= '0;
         stop_q <= '0;
         delay_q <= 32'h0000_0000;
         state_q <= indexer_pkg::EX_RUN;
         cnt_q <= '{default: 16'h0000};
         ret_q <= '{default: '0};
      end else if (kill) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         depth_q <= '0;
         stop_q <= '0;
         delay_q <= 32'h0000_0000;
         state_q <= indexer_pkg::EX_RUN;
      end else begin
         if (reclaim) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= push ? (QW+1)'(1) : '0;
         end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (state_q == indexer_pkg::EX_WAIT) begin
            if (tick_q) begin
               delay_q <= delay_q - 1;
               if (delay_q <= 32'h0000_0001) begin
                  state_q <= indexer_pkg::EX_RUN;
               end
            end
         end else if (exec_go) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
            unique case (cur.op)
               indexer_pkg::OP_LOOP_BEGIN: begin
                  if (depth_q < (DW+1)'(LOOP_DEPTH) && arg_ok(cur.op, cur.arg)) begin
                     cnt_q[depth_q[DW-1:0]] <= cur.arg[15:0];
                     ret_q[depth_q[DW-1:0]] <= rd_ptr_q + 1'b1;
                     stop_q[depth_q[DW-1:0]] <= 1'b0;
                     depth_q <= depth_q + 1'b1;
                  end
               end
               indexer_pkg::OP_LOOP_END: begin
                  if (depth_q != '0) begin
                     if (stop_q[top] || cnt_q[top] == 16'h0001) begin
                        depth_q <= depth_q - 1'b1;
                     end else begin
                        if (cnt_q[top] != 16'h0000) begin
                           cnt_q[top] <= cnt_q[top] - 1'b1;
                        end
                        rd_ptr_q <= ret_q[top];
                     end
                  end
               end
               indexer_pkg::OP_LOOP_STOP: begin
                  if (depth_q != '0) begin
                     stop_q[top] <= 1'b1;
                  end
               end
               indexer_pkg::OP_DELAY: begin
                  delay_q <= cur.arg;
                  if (cur.arg != 32'h0000_0000) begin
                     state_q <= indexer_pkg::EX_WAIT;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pause_q <= 1'b0;
      end else if (kill) begin
         pause_q <= 1'b0;
      end else if (pause_cmd) begin
         pause_q <= 1'b1;
      end else if (cont_cmd) begin
         pause_q <= 1'b0;
      end
   end

   // Settings, kept across kill
   logic [31:0] jog_accel_rate_q;
   logic [31:0] jog_speed_max_q;
   logic [31:0] limit_decel_rate_q;
   logic [1:0] end_stop_disable_q;
   logic set_ok;
   assign set_ok = exec_go && arg_ok(cur.op, cur.arg);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         jog_accel_rate_q <= indexer_pkg::JOG_ACCEL_RESET;
         jog_speed_max_q <= indexer_pkg::JOG_SPEED_RESET;
         limit_decel_rate_q <= indexer_pkg::LIMIT_DECEL_RESET;
         end_stop_disable_q <= indexer_pkg::END_STOP_RESET;
      end else if (set_ok) begin
         if (cur.op == indexer_pkg::OP_JOG_ACCEL) jog_accel_rate_q <= cur.arg;
         if (cur.op == indexer_pkg::OP_JOG_SPEED) jog_speed_max_q <= cur.arg;
         if (cur.op == indexer_pkg::OP_LIMIT_DECEL) limit_decel_rate_q <= cur.arg;
         if (cur.op == indexer_pkg::OP_END_STOP) end_stop_disable_q <= cur.arg[1:0];
      end
   end

   // Motion profile
   logic cw_block;
   logic ccw_block;
   logic want_cw;
   logic want_ccw;
   logic want;
   logic blocked;
   logic [31:0] speed_tgt;
   logic [31:0] vel_d;
   logic dir_d;
   assign cw_block = !end_stop_disable_q[0] && pins.lim_cw;
   assign ccw_block = !end_stop_disable_q[1] && pins.lim_ccw;
   assign want_cw = pins.jog_cw && !pins.jog_ccw;
   assign want_ccw = pins.jog_ccw && !pins.jog_cw;
   assign want = motor_dir ? want_ccw : want_cw;
   assign blocked = motor_dir ? ccw_block : cw_block;
   assign speed_tgt = 32'(jog_speed_max_q * indexer_pkg::SPEED_SCALE);

   always_comb begin
      vel_d = motor_speed;
      dir_d = motor_dir;
      if (kill) begin
         vel_d = 32'h0000_0000;
      end else if (tick_q) begin
         if (blocked) begin
            vel_d = step_down(motor_speed, limit_decel_rate_q);
         end else if (want && motor_speed < speed_tgt) begin
            vel_d = (speed_tgt - motor_speed > jog_accel_rate_q) ?
                    motor_speed + jog_accel_rate_q : speed_tgt;
         end else if (!want || motor_speed > speed_tgt) begin
            vel_d = step_down(motor_speed, jog_accel_rate_q);
         end
         if (motor_speed == 32'h0000_0000 && !want) begin
            dir_d = want_ccw;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         motor_speed <= 32'h0000_0000;
         motor_dir <= 1'b0;
         motor_run <= 1'b0;
         trigger <= 5'h00;
      end else begin
         motor_speed <= vel_d;
         motor_dir <= dir_d;
         motor_run <= vel_d != 32'h0000_0000;
         trigger <= {pins.lim_ccw & end_stop_disable_q[1],
                     pins.lim_cw & end_stop_disable_q[0], pins.trig};
      end
   end

   // Sticky flags, all cleared by kill
   logic arg_err_q;
   logic queue_full_q;
   logic limit_hit_q;
   logic [31:0] flag_word;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         arg_err_q <= 1'b0;
         queue_full_q <= 1'b0;
         limit_hit_q <= 1'b0;
      end else if (kill) begin
         arg_err_q <= 1'b0;
         queue_full_q <= 1'b0;
         limit_hit_q <= 1'b0;
      end else begin
         arg_err_q <= arg_err_q || (exec_go && !arg_ok(cur.op, cur.arg)) ||
                      (issue && op_in > indexer_pkg::OP_DELAY);
         queue_full_q <= queue_full_q || (buffered && full);
         limit_hit_q <= limit_hit_q || (tick_q && blocked && motor_speed != 32'h0000_0000);
      end
   end

   always_comb begin
      flag_word = 32'h0000_0000;
      flag_word[indexer_pkg::FLAG_PAUSE] = pause_q;
      flag_word[indexer_pkg::FLAG_ARG_ERR] = arg_err_q;
      flag_word[indexer_pkg::FLAG_QUEUE_FULL] = queue_full_q;
      flag_word[indexer_pkg::FLAG_LIMIT_HIT] = limit_hit_q;
      flag_word[indexer_pkg::FLAG_DELAY] = state_q == indexer_pkg::EX_WAIT;
      flag_word[indexer_pkg::FLAG_LOOPING] = depth_q != '0;
   end

   always_comb begin
      unique case (haddr[7:0])
         indexer_pkg::OFF_CMD_ARG: rd_word = arg_q;
         indexer_pkg::OFF_GPO: rd_word = 32'(gpo);
         indexer_pkg::OFF_INPUT_STATUS: rd_word = {22'h00_0000, pins_q};
         indexer_pkg::OFF_JOG_ACCEL: rd_word = jog_accel_rate_q;
         indexer_pkg::OFF_JOG_SPEED: rd_word = jog_speed_max_q;
         indexer_pkg::OFF_LIMIT_DECEL: rd_word = limit_decel_rate_q;
         indexer_pkg::OFF_END_STOP: rd_word = {30'h0000_0000, end_stop_disable_q};
         indexer_pkg::OFF_FLAGS: rd_word = flag_word;
         indexer_pkg::OFF_LOOP_STATUS:
            rd_word = {11'h000, 5'(depth_q), (depth_q != '0) ? cnt_q[top] : 16'h0000};
         indexer_pkg::OFF_MOTION: rd_word = motor_speed;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   gpo_follow_a: assert property (out_set |=> gpo == $past(arg_q[GPO_W-1:0]))
      else $error("gpo did not take output pattern");
   input_live_a: assert property (addr_rd && haddr == 32'(indexer_pkg::OFF_INPUT_STATUS)
      |=> hrdata == {22'h00_0000, $past(pins_q)}) else $error("input status not live");
   jog_accel_range_a: assert property (jog_accel_rate_q >= indexer_pkg::JOG_ACCEL_MIN
      && jog_accel_rate_q <= indexer_pkg::JOG_ACCEL_MAX) else $error("jog accel out of range");
   jog_speed_range_a: assert property (jog_speed_max_q <= indexer_pkg::JOG_SPEED_MAX)
      else $error("jog speed out of range");
   jog_hold_a: assert property (tick_q && !kill && want && !blocked &&
      motor_speed == speed_tgt |=> motor_speed == $past(speed_tgt)) else $error("jog not held");
   kill_stop_a: assert property (kill |=> motor_speed == 32'h0000_0000 && !motor_run)
      else $error("kill did not stop motor");
   kill_flags_a: assert property (kill |=> flag_word == 32'h0000_0000)
      else $error("kill left a flag set");
   kill_queue_a: assert property (kill |=> wr_ptr_q == '0 && rd_ptr_q == '0
      && depth_q == '0 && state_q == indexer_pkg::EX_RUN) else $error("kill left work queued");
   loop_repeat_a: assert property (exec_go && cur.op == indexer_pkg::OP_LOOP_END
      && depth_q != '0 && !stop_q[top] && cnt_q[top] != 16'h0001
      |=> rd_ptr_q == $past(ret_q[top])) else $error("loop did not return");
   loop_forever_a: assert property (exec_go && cur.op == indexer_pkg::OP_LOOP_END
      && depth_q != '0 && !stop_q[top] && cnt_q[top] == 16'h0000
      |=> depth_q == $past(depth_q)) else $error("endless loop exited");
   loop_stop_a: assert property (exec_go && cur.op == indexer_pkg::OP_LOOP_END
      && depth_q != '0 && stop_q[top] |=> depth_q == $past(depth_q) - 1'b1)
      else $error("stopped loop did not exit");
   pause_hold_a: assert property (pause_q && !kill && rd_ptr_q != wr_ptr_q
      && state_q == indexer_pkg::EX_RUN |=> $stable(rd_ptr_q)) else $error("ran while paused");
   nest_depth_a: assert property (depth_q <= (DW+1)'(LOOP_DEPTH))
      else $error("loop nesting overflow");
   limit_decel_a: assert property (tick_q && !kill && blocked
      && motor_speed >= limit_decel_rate_q
      |=> motor_speed == $past(motor_speed) - $past(limit_decel_rate_q))
      else $error("limit decel rate not applied");
   limits_on_a: assert property (end_stop_disable_q == 2'h0 && pins.lim_cw
      && pins.lim_ccw && !motor_run |=> !motor_run) else $error("moved with limits open");
   limits_off_a: assert property (end_stop_disable_q == 2'h3 |-> !cw_block && !ccw_block)
      else $error("disabled limit still blocks");
   trigger_reuse_a: assert property (##1 trigger[4:3] ==
      $past({pins.lim_ccw & end_stop_disable_q[1], pins.lim_cw & end_stop_disable_q[0]}))
      else $error("disabled limit not a trigger");
endmodule : indexer_core

// ### core/indexer_pkg.sv
// Package for the indexer command interpreter: register map, opcodes,
// parameter ranges, reset values, timing and carrier types.
// Assumes one 200 MHz clock and 32-bit AHB-Lite register access.
package indexer_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CMD_ARG = 8'h00;
   localparam logic [7:0] OFF_CMD_OP = 8'h04;
   localparam logic [7:0] OFF_GPO = 8'h08;
   localparam logic [7:0] OFF_INPUT_STATUS = 8'h0C;
   localparam logic [7:0] OFF_JOG_ACCEL = 8'h10;
   localparam logic [7:0] OFF_JOG_SPEED = 8'h14;
   localparam logic [7:0] OFF_LIMIT_DECEL = 8'h18;
   localparam logic [7:0] OFF_END_STOP = 8'h1C;
   localparam logic [7:0] OFF_FLAGS = 8'h20;
   localparam logic [7:0] OFF_LOOP_STATUS = 8'h24;
   localparam logic [7:0] OFF_MOTION = 8'h28;
   // Opcodes written to the command register
   localparam logic [7:0] OP_OUTPUT_SET = 8'h01;
   localparam logic [7:0] OP_KILL = 8'h02;
   localparam logic [7:0] OP_KILL_LONG = 8'h03;
   localparam logic [7:0] OP_PAUSE = 8'h04;
   localparam logic [7:0] OP_CONTINUE = 8'h05;
   localparam logic [7:0] OP_LOOP_BEGIN = 8'h10;
   localparam logic [7:0] OP_LOOP_END = 8'h11;
   localparam logic [7:0] OP_LOOP_STOP = 8'h12;
   localparam logic [7:0] OP_JOG_ACCEL = 8'h13;
   localparam logic [7:0] OP_JOG_SPEED = 8'h14;
   localparam logic [7:0] OP_LIMIT_DECEL = 8'h15;
   localparam logic [7:0] OP_END_STOP = 8'h16;
   localparam logic [7:0] OP_DELAY = 8'h17;
   // Ranges in thousandths (rates) and hundredths (speed)
   localparam logic [31:0] JOG_ACCEL_MIN = 32'h0000_0001;
   localparam logic [31:0] JOG_ACCEL_MAX = 32'h0001_869F;
   localparam logic [31:0] JOG_ACCEL_RESET = 32'h0001_82B8;
   localparam logic [31:0] JOG_SPEED_MAX = 32'h0000_1388;
   localparam logic [31:0] JOG_SPEED_RESET = 32'h0000_0064;
   localparam logic [31:0] LIMIT_DECEL_MIN = 32'h0000_0001;
   localparam logic [31:0] LIMIT_DECEL_MAX = 32'h7FFF_FFFF;
   localparam logic [31:0] LIMIT_DECEL_RESET = 32'h000D_BBA0;
   localparam logic [31:0] END_STOP_MAX = 32'h0000_0003;
   localparam logic [1:0] END_STOP_RESET = 2'h0;
   localparam logic [31:0] LOOP_COUNT_MAX = 32'h0000_FFFF;
   localparam logic [31:0] SPEED_SCALE = 32'h0000_2710;
   localparam int unsigned LOOP_DEPTH_MAX = 16;
   // Flag bit positions
   localparam int unsigned FLAG_PAUSE = 0;
   localparam int unsigned FLAG_ARG_ERR = 1;
   localparam int unsigned FLAG_QUEUE_FULL = 2;
   localparam int unsigned FLAG_LIMIT_HIT = 3;
   localparam int unsigned FLAG_DELAY = 4;
   localparam int unsigned FLAG_LOOPING = 5;
   // Motion tick: one millisecond
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [7:0] op;
      logic [31:0] arg;
   } cmd_entry_type;

   typedef struct packed {
      logic jog_ccw;
      logic jog_cw;
      logic lim_ccw;
      logic lim_cw;
      logic [2:0] seq;
      logic [2:0] trig;
   } pins_type;

   typedef enum logic {
      EX_RUN = 1'b0,
      EX_WAIT = 1'b1
   } exec_state_type;
endpackage : indexer_pkg

// ### sim/indexer_jog_kill_loop_limits_tb.sv
// Self-checking bench for indexer_core against a register-map model.
// Assumes switch_model drives the pins and the AHB-Lite slave is alone on the bus.
`timescale 1ns/1ps
module indexer_jog_kill_loop_limits_tb;
   logic sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, motor_speed;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [9:0] pin_set = 10'h000;
   logic [7:0] gpo;
   logic [4:0] trigger;
   logic hresp, motor_dir, motor_run;
   indexer_pkg::pins_type pins_raw;
   int fail_count = 0, num_checks = 0;
   logic [31:0] mdl [logic [7:0]];
   always #2.5 sys_clk = ~sys_clk;
   switch_model i_sw (.sys_clk(sys_clk), .set_val(pin_set), .pins(pins_raw));
   indexer_core #(.TICK_CYCLES(20)) i_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .pins_raw(pins_raw), .gpo(gpo), .motor_speed(motor_speed), .motor_dir(motor_dir),
      .motor_run(motor_run), .trigger(trigger));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic cmd(input logic [7:0] op, input logic [31:0] arg);
      ahb(1'b1, indexer_pkg::OFF_CMD_ARG, arg);
      ahb(1'b1, indexer_pkg::OFF_CMD_OP, {24'h000000, op});
      // Buffered commands run one per cycle; leave room for the queue to drain
      repeat (4) @(posedge sys_clk);
   endtask : cmd
   task automatic regs();
      foreach (mdl[a]) begin
         ahb(1'b0, a, 32'h0);
         chk(rd, mdl[a]);
         chk({31'h0, hresp}, 32'h0);
      end
   endtask : regs
   task automatic results();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   initial begin
      #200000;
      fail_count++;
      results();
   end
   initial begin
      logic [31:0] v, w;
      void'($urandom(76903));
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      mdl[indexer_pkg::OFF_JOG_ACCEL] = indexer_pkg::JOG_ACCEL_RESET;
      mdl[indexer_pkg::OFF_JOG_SPEED] = indexer_pkg::JOG_SPEED_RESET;
      mdl[indexer_pkg::OFF_LIMIT_DECEL] = indexer_pkg::LIMIT_DECEL_RESET;
      mdl[indexer_pkg::OFF_END_STOP] = 32'h0;
      mdl[indexer_pkg::OFF_FLAGS] = 32'h0;
      mdl[indexer_pkg::OFF_LOOP_STATUS] = 32'h0;
      mdl[indexer_pkg::OFF_GPO] = 32'h0;
      regs();
      v = $urandom;
      cmd(indexer_pkg::OP_OUTPUT_SET, v);
      mdl[indexer_pkg::OFF_GPO] = {24'h000000, v[7:0]};
      chk({24'h000000, gpo}, mdl[indexer_pkg::OFF_GPO]);
      v = $urandom_range(99999, 1);
      cmd(indexer_pkg::OP_JOG_ACCEL, v);
      mdl[indexer_pkg::OFF_JOG_ACCEL] = v;
      regs();
      for (int k = 0; k < 2; k++) begin
         cmd(indexer_pkg::OP_JOG_ACCEL, 32'h0001_86A0);
         cmd(indexer_pkg::OP_PAUSE, 32'h0);
         cmd(indexer_pkg::OP_LOOP_BEGIN, 32'h0000_0005);
         mdl[indexer_pkg::OFF_FLAGS] = 32'h0000_0003;
         regs();
         cmd(k ? indexer_pkg::OP_KILL_LONG : indexer_pkg::OP_KILL, 32'h0);
         cmd(indexer_pkg::OP_CONTINUE, 32'h0);
         mdl[indexer_pkg::OFF_FLAGS] = 32'h0;
         regs();
      end
      for (int e = 0; e < 4; e++) begin
         cmd(indexer_pkg::OP_END_STOP, e);
         mdl[indexer_pkg::OFF_END_STOP] = e;
         v = $urandom;
         pin_set <= {4'h3, v[5:0]};
         repeat (8) @(posedge sys_clk);
         chk({27'h0, trigger}, {27'h0, e[1], e[0], v[2:0]});
         ahb(1'b0, indexer_pkg::OFF_INPUT_STATUS, 32'h0);
         chk(rd, {22'h0, 4'h3, v[5:0]});
         regs();
      end
      cmd(indexer_pkg::OP_END_STOP, 32'h0);
      pin_set <= 10'h1C0;
      repeat (120) @(posedge sys_clk);
      chk({31'h0, motor_run}, 32'h0);
      cmd(indexer_pkg::OP_END_STOP, 32'h3);
      for (int d = 0; d < 2; d++) begin
         pin_set <= d ? 10'h2C0 : 10'h1C0;
         repeat (120) @(posedge sys_clk);
         chk({30'h0, motor_dir, motor_run}, {30'h0, d[0], 1'b1});
         // Release the jog first so that no later tick can restart the motor
         pin_set <= 10'h0C0;
         repeat (8) @(posedge sys_clk);
         cmd(d ? indexer_pkg::OP_KILL_LONG : indexer_pkg::OP_KILL, 32'h0);
         chk(motor_speed, 32'h0);
      end
      cmd(indexer_pkg::OP_LOOP_BEGIN, 32'h0);
      cmd(indexer_pkg::OP_LOOP_END, 32'h0);
      mdl[indexer_pkg::OFF_LOOP_STATUS] = 32'h0001_0000;
      mdl[indexer_pkg::OFF_FLAGS] = 32'h0000_0020;
      regs();
      cmd(indexer_pkg::OP_KILL, 32'h0);
      cmd(indexer_pkg::OP_PAUSE, 32'h0);
      cmd(indexer_pkg::OP_LOOP_BEGIN, 32'h0000_0003);
      cmd(indexer_pkg::OP_DELAY, 32'h0000_0001);
      cmd(indexer_pkg::OP_LOOP_BEGIN, 32'h0);
      cmd(indexer_pkg::OP_LOOP_STOP, 32'h0);
      cmd(indexer_pkg::OP_LOOP_END, 32'h0);
      cmd(indexer_pkg::OP_LOOP_END, 32'h0);
      v = $urandom_range(indexer_pkg::JOG_SPEED_MAX, 0);
      w = $urandom_range(indexer_pkg::LIMIT_DECEL_MAX, 1);
      cmd(indexer_pkg::OP_JOG_SPEED, v);
      cmd(indexer_pkg::OP_LIMIT_DECEL, w);
      mdl[indexer_pkg::OFF_LOOP_STATUS] = 32'h0;
      mdl[indexer_pkg::OFF_FLAGS] = 32'h0000_0001;
      regs();
      cmd(indexer_pkg::OP_CONTINUE, 32'h0);
      repeat (200) @(posedge sys_clk);
      mdl[indexer_pkg::OFF_JOG_SPEED] = v;
      mdl[indexer_pkg::OFF_LIMIT_DECEL] = w;
      mdl[indexer_pkg::OFF_FLAGS] = 32'h0;
      regs();
      results();
   end
endmodule : indexer_jog_kill_loop_limits_tb

// ### sim/switch_model.sv
// Switch and jog-pin model: drives the indexer pins from levels set by the bench.
// Assumes the bench changes the levels right after a rising clock edge.
`timescale 1ns/1ps
module switch_model (
   input wire logic sys_clk,
   input wire logic [9:0] set_val,
   output indexer_pkg::pins_type pins
);
   // Pins move shortly after the edge, unrelated to the indexer's sampling
   always @(posedge sys_clk) pins <= #1 indexer_pkg::pins_type'(set_val);
endmodule : switch_model
